// >>> rtl/gain_cfg_defs.svh
// offsets, field positions, reset values and codes of the gain and energy mode register
// ==========================================================================
// Notes on behaviour
// - Bits 1:0 set the current gain: code 00 is 1, 01 is 2, 10 is 4, 11 is reserved.
// - Bits 6:5 set the voltage gain: code 00 is 1, 01 is 2, 10 is 4, 11 is reserved.
// - Bit 2 set sums absolute phase energies into total and line-cycle energy, else signed.
// - Bit 3 clear drops a phase's energy from totals under the no-load power threshold.
`ifndef GAIN_CFG_DEFS_SVH
`define GAIN_CFG_DEFS_SVH

`define GAIN_REG_OFFSET 8'h18
`define GAIN_REG_RESET 8'h00
`define CUR_GAIN_LSB 0
`define CUR_GAIN_MSB 1
`define SUM_ABS_BIT 2
`define NO_LOAD_BIT 3
`define TEST0_BIT 4
`define VOLT_GAIN_LSB 5
`define VOLT_GAIN_MSB 6
`define TEST1_BIT 7
`define GAIN_CODE_X1 2'h0
`define GAIN_CODE_X2 2'h1
`define GAIN_CODE_X4 2'h2
`define GAIN_CODE_RSV 2'h3

`endif

// >>> rtl/gain_cfg_pkg.sv
// types of the gain and energy mode register block
package gain_cfg_pkg;
	typedef struct packed {
		logic [7:0] cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [2:0] cur_mult;
		logic [2:0] volt_mult;
		logic absolute_sum_mode;
		logic no_load_suppress;
		logic gain_reserved;
		logic test_bits_set;
	} gain_cfg_state_t;
endpackage : gain_cfg_pkg

// >>> rtl/gain_and_accumulation_config.sv
// apb slave holding the input gain and energy accumulation mode register
`timescale 1ns/100ps
`include "gain_cfg_defs.svh"
module gain_and_accumulation_config
	import gain_cfg_pkg::*;
(
	input wire logic pclk, // bus clock, 10 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // slave select
	input wire logic penable, // access phase
	input wire logic pwrite, // 1 write, 0 read
	input wire logic [7:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	output logic [31:0] prdata, // read data
	output logic pready, // transfer done
	output logic pslverr, // unmapped address
	output logic [2:0] cur_mult, // current gain factor 1, 2 or 4, or 0 for the reserved code
	output logic [2:0] volt_mult, // voltage gain factor 1, 2 or 4, or 0 for the reserved code
	output logic absolute_sum_mode, // sum absolute phase energies
	output logic no_load_suppress, // drop energy under no-load threshold
	output logic gain_reserved, // a reserved gain code is held
	output logic test_bits_set // a factory-test bit is nonzero
);
	// ==================================================================
	// state
	// every output is a field of this copy, so each one leaves a flip-flop
	gain_cfg_state_t cur;
	gain_cfg_state_t next_st;

	// ==================================================================
	// bus decode
	// an access is taken only while pready is low, so the pready cycle
	// of the same access phase is never taken a second time
	function automatic logic access_taken(
		input logic sel, // slave select
		input logic enable, // access phase
		input logic ready // answer already given
	);
		access_taken = sel & enable & ~ready;
	endfunction : access_taken

	// the whole byte address is compared, so no alias of the register exists
	function automatic logic addr_hit(
		input logic [7:0] addr // byte address
	);
		addr_hit = (addr == `GAIN_REG_OFFSET);
	endfunction : addr_hit

	// the register sits in the low byte; the upper lanes read as zero
	function automatic logic [31:0] read_word(
		input logic [7:0] value // stored register byte
	);
		read_word = {24'h00_0000, value};
	endfunction : read_word

	// ==================================================================
	// field decode
	function automatic logic [1:0] cur_code(
		input logic [7:0] value // register byte
	);
		cur_code = value[`CUR_GAIN_MSB:`CUR_GAIN_LSB];
	endfunction : cur_code

	function automatic logic [1:0] volt_code(
		input logic [7:0] value // register byte
	);
		volt_code = value[`VOLT_GAIN_MSB:`VOLT_GAIN_LSB];
	endfunction : volt_code

	// reserved code gives factor 0 so downstream sees no valid gain
	function automatic logic [2:0] gain_factor(
		input logic [1:0] code // two-bit gain code
	);
		case (code)
			`GAIN_CODE_X1: begin
				gain_factor = 3'h1;
			end
			`GAIN_CODE_X2: begin
				gain_factor = 3'h2;
			end
			`GAIN_CODE_X4: begin
				gain_factor = 3'h4;
			end
			default: begin
				gain_factor = 3'h0;
			end
		endcase
	endfunction : gain_factor

	function automatic logic code_reserved(
		input logic [1:0] code // two-bit gain code
	);
		code_reserved = (code == `GAIN_CODE_RSV);
	endfunction : code_reserved

	// the factory-test bits are only watched, never acted on
	function automatic logic test_bits(
		input logic [7:0] value // register byte
	);
		test_bits = value[`TEST0_BIT] | value[`TEST1_BIT];
	endfunction : test_bits

	// ==================================================================
	// next state
	always_comb begin
		logic [7:0] value;
		logic take;
		logic hit;
		logic wr;
		logic rd;
		value = cur.cfg;
		take = access_taken(psel, penable, cur.pready);
		hit = addr_hit(paddr);
		wr = take & hit & pwrite;
		rd = take & hit & ~pwrite;
		next_st = cur;

		// one wait state: ready rises in the cycle after the first access cycle
		next_st.pready = take;
		// an unmapped address is answered and flagged, and nothing is stored
		next_st.pslverr = take & ~hit;

		// the write lands at the edge that ends the first access cycle, so the
		// derived outputs already show it in the pready cycle
		if (wr) begin
			// test bits stored as written so misuse stays visible
			value = pwdata[7:0];
		end
		next_st.cfg = value;

		// read data stands for the pready cycle only and is zero otherwise
		if (rd) begin
			next_st.prdata = read_word(cur.cfg);
		end else begin
			next_st.prdata = 32'h0000_0000;
		end

		// derived outputs follow the byte that the register will hold
		next_st.cur_mult = gain_factor(cur_code(value));
		next_st.volt_mult = gain_factor(volt_code(value));
		next_st.absolute_sum_mode = value[`SUM_ABS_BIT];
		next_st.no_load_suppress = ~value[`NO_LOAD_BIT];
		next_st.gain_reserved = code_reserved(cur_code(value)) |
			code_reserved(volt_code(value));
		next_st.test_bits_set = test_bits(value);
	end

	// ==================================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur.cfg <= `GAIN_REG_RESET;
			cur.prdata <= 32'h0000_0000;
			cur.pready <= 1'b0;
			cur.pslverr <= 1'b0;
			cur.cur_mult <= 3'h1;
			cur.volt_mult <= 3'h1;
			cur.absolute_sum_mode <= 1'b0;
			cur.no_load_suppress <= 1'b1;
			cur.gain_reserved <= 1'b0;
			cur.test_bits_set <= 1'b0;
		end else begin
			cur <= next_st;
		end
	end

	// ==================================================================
	// outputs
	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign cur_mult = cur.cur_mult;
	assign volt_mult = cur.volt_mult;
	assign absolute_sum_mode = cur.absolute_sum_mode;
	assign no_load_suppress = cur.no_load_suppress;
	assign gain_reserved = cur.gain_reserved;
	assign test_bits_set = cur.test_bits_set;
endmodule : gain_and_accumulation_config

// >>> dv/gain_cfg_asserts.sv
// port checks of the gain and energy mode register
`timescale 1ns/100ps
module gain_cfg_asserts (
	input wire logic pclk, // clk
	input wire logic presetn, // rst
	input wire logic pwrite, // dir
	input wire logic [31:0] prdata, // data
	input wire logic pready, // done
	input wire logic pslverr, // err
	input wire logic [2:0] cur_mult, // gain
	input wire logic [2:0] volt_mult, // gain
	input wire logic absolute_sum_mode, // sum
	input wire logic no_load_suppress, // drop
	input wire logic gain_reserved, // reserved gain code held
	input wire logic test_bits_set // factory-test bit set
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========
	// read-back ties each output to the stored bits
	wire rd = pready && !pwrite && !pslverr;
	cur_gain_a: assert property (rd |->
		cur_mult == (&prdata[1:0] ? 3'h0 : 3'h1 << prdata[1:0])) else $error("cur gain");
	volt_gain_a: assert property (rd |->
		volt_mult == (&prdata[6:5] ? 3'h0 : 3'h1 << prdata[6:5])) else $error("volt gain");
	sum_mode_a: assert property (rd |-> absolute_sum_mode == prdata[2])
		else $error("sum mode");
	no_load_a: assert property (rd |-> no_load_suppress == !prdata[3])
		else $error("no load");
	gain_rsv_a: assert property (rd |-> gain_reserved == (&prdata[1:0] || &prdata[6:5]))
		else $error("reserved gain");
	test_bits_a: assert property (rd |-> test_bits_set == (prdata[4] || prdata[7]))
		else $error("test bits");
	upper_lane_a: assert property (rd |-> prdata[31:8] == 24'h00_0000)
		else $error("upper lanes");
	reset_vals_a: assert property ($rose(presetn) |-> cur_mult == 3'h1
		&& volt_mult == 3'h1 && !absolute_sum_mode && no_load_suppress
		&& !gain_reserved && !test_bits_set) else $error("reset");
endmodule : gain_cfg_asserts
bind gain_and_accumulation_config gain_cfg_asserts u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.pwrite(pwrite),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.cur_mult(cur_mult),
	.volt_mult(volt_mult),
	.absolute_sum_mode(absolute_sum_mode),
	.no_load_suppress(no_load_suppress),
	.gain_reserved(gain_reserved),
	.test_bits_set(test_bits_set)
);

// >>> dv/gain_and_accumulation_config_test.sv
// bench of the gain and energy mode register
`timescale 1ns/100ps
module gain_and_accumulation_config_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00, d;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic absolute_sum_mode, no_load_suppress, gain_reserved, test_bits_set;
	logic [2:0] cur_mult, volt_mult;
	int fails = 0, checks = 0, cyc = 0;
	gain_and_accumulation_config u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cur_mult(cur_mult),
		.volt_mult(volt_mult),
		.absolute_sum_mode(absolute_sum_mode),
		.no_load_suppress(no_load_suppress),
		.gain_reserved(gain_reserved),
		.test_bits_set(test_bits_set)
	);
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) if (++cyc == 2000) begin
		fails++;
		test_done();
	end
	task automatic test_done();
		if (fails == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: word %h not %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_mult(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: factor %h not %h", $time, got, exp);
		end
	endtask : chk_mult
	task automatic chk_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: flag %b not %b", $time, got, exp);
		end
	endtask : chk_flag
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
		chk_flag(err, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = {1'b0, 2'(3 - i), 1'b0, 2'(i), 2'(i)};
			// upper data lanes carry junk that the register must ignore
			apb(1'b1, 8'h18, {24'hA5_A5A5, d});
			apb(1'b0, 8'h18, 32'h0000_0000);
			chk_word(rd, {24'h00_0000, d});
			chk_flag(absolute_sum_mode, i[0]);
			chk_flag(no_load_suppress, !i[1]);
			chk_mult(cur_mult, 3'(i == 3 ? 0 : 1 << i));
			chk_mult(volt_mult, 3'(i == 0 ? 0 : 1 << 3 - i));
			chk_flag(gain_reserved, i == 0 || i == 3);
			chk_flag(test_bits_set, 1'b0);
		end
		// unmapped accesses are flagged and leave the register alone
		apb(1'b1, 8'h1C, 32'h0000_0063);
		chk_flag(err, 1'b1);
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk_flag(err, 1'b1);
		chk_word(rd, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk_word(rd, 32'h0000_000F);
		// a second reset in mid-run returns every field to its default
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_mult(cur_mult, 3'h1);
		chk_mult(volt_mult, 3'h1);
		chk_flag(absolute_sum_mode, 1'b0);
		chk_flag(no_load_suppress, 1'b1);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
		test_done();
	end
endmodule : gain_and_accumulation_config_test
